// ### src/smr_stop_ctrl.sv
// stop mode entry and release sequencer
// assumes synchronous pins and a one-cycle-latency register port
// Operation
// - writing one to the stop bit enters stop
// - in stop both oscillators halt and the core clock is gated
// - any reset ends stop; then warm-up and single-clock fast run
// - release select one means level release, zero means edge release
// - level mode: stop pin high releases stop
// - level mode: stop request ignored while pin is high
// - pin going low during warm-up does not re-enter stop
// - edge mode: rising pin edge releases stop
// - edge mode: stop entered even when pin is high
// - pin edge within one machine cycle of request is ignored
// - key wakeup releases at selectable high or low level
// - key returning during warm-up does not re-enter stop
// - detector reset ends stop and resets at once
// - detector recovery releases reset, warms up, fast single mode
// - detector recovery within one machine cycle of request ignored
// - restart oscillators, hold core during warm-up, then resume
// - prescaler and divider cleared when execution resumes
// - warm-up source follows clock used before stop
// - restart oscillators by prior mode
// - dual-clock fast: high clock feeds warm-up divider
// - irq pin may latch during stop; accepted after release
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module smr_stop_ctrl
  import smr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // release sources
  input wire logic stop_pin_i,
  input wire logic key_i,
  input wire logic vd_low_i,
  input wire logic ext_reset_i,
  input wire logic irq_pin_i,
  // clock and core control
  output logic hf_osc_en_o,
  output logic lf_osc_en_o,
  output logic core_halt_o,
  output logic tg_clear_o,
  output logic sys_reset_o,
  output logic wu_src_hf_o,
  output logic irq_latch_o,
  output logic [1:0] run_mode_o
);
  // ***********************************************************
  // state and registers
  // ***********************************************************
  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WARM, ST_RESET} smr_state_e;
  smr_state_e state;
  smr_state_e next_state;
  logic release_mode_select;
  logic vd_reset_en;
  logic [1:0] mode;
  logic [7:0] wu_count;
  logic [7:0] wu_ctrl;
  logic key_level;
  logic [3:0] blind;
  logic [1:0] held_mode;
  logic irq_latch;
  logic pin_rise;
  logic vd_high;
  logic vd_rise;
  logic wu_busy;
  logic wu_done;
  logic wu_start;
  logic any_reset;

  // ***********************************************************
  // decode
  // ***********************************************************
  wire wr_ctrl = wr_i & (addr_i == OFS_SYS_CTRL_ONE);
  wire wr_wcount = wr_i & (addr_i == OFS_WARMUP_COUNT);
  wire wr_wctrl = wr_i & (addr_i == OFS_WARMUP_CTRL);
  wire wr_key = wr_i & (addr_i == OFS_KEY_CTRL);
  wire new_release_mode_select = wdata_i[BIT_RELEASE_MODE_SELECT];
  // level mode refuses entry while the pin is high
  wire stop_req = wr_ctrl & wdata_i[BIT_STOP] & ~(new_release_mode_select & stop_pin_i);
  wire blind_on = (blind != 4'h0);
  wire pin_rel = release_mode_select ? stop_pin_i : (pin_rise & ~blind_on);
  wire key_rel = (key_i == key_level);
  // supply recovery is a release source too, blinded like the pin edge
  wire vd_rel = vd_rise & ~blind_on;
  wire any_rel = pin_rel | key_rel | vd_rel;
  wire vd_trip = vd_reset_en & vd_low_i;
  assign any_reset = ext_reset_i | vd_trip;
  assign vd_high = ~vd_low_i;

  smr_edge_det u_pin_edge (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .level_i(stop_pin_i),
    .rise_o(pin_rise)
  );

  smr_edge_det u_vd_edge (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .level_i(vd_high),
    .rise_o(vd_rise)
  );

  // ***********************************************************
  // warm-up counter
  // ***********************************************************
  assign wu_start = ((state == ST_STOP) & any_rel & ~any_reset)
                  | ((state == ST_RESET) & ~any_reset);
  smr_warmup_cnt u_warmup (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .start_i(wu_start),
    .count_i(wu_count),
    .div_i(WU_TICK_DIV),
    .busy_o(wu_busy),
    .done_o(wu_done)
  );

  // ***********************************************************
  // next state
  // ***********************************************************
  // warm state ignores the stop pin and key, so a falling pin or key cannot re-stop
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (stop_req) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (wu_start) begin
          next_state = ST_WARM;
        end
      end
      ST_WARM: begin
        if (wu_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RESET: begin
        if (wu_start) begin
          next_state = ST_WARM;
        end
      end
    endcase
    if (any_reset) begin
      next_state = ST_RESET;
    end
  end

  // ***********************************************************
  // registers and sequencing
  // ***********************************************************
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= ST_RESET;
      release_mode_select <= RST_SYS_CTRL_ONE[BIT_RELEASE_MODE_SELECT];
      vd_reset_en <= RST_SYS_CTRL_ONE[BIT_VD_RESET_EN];
      mode <= RST_SYS_CTRL_ONE[1:0];
      held_mode <= 2'h0;
      wu_count <= RST_WARMUP_COUNT;
      wu_ctrl <= RST_WARMUP_CTRL;
      key_level <= RST_KEY_CTRL[0];
      blind <= 4'h0;
      irq_latch <= 1'b0;
    end else begin
      state <= next_state;
      if (wr_ctrl) begin
        release_mode_select <= new_release_mode_select;
        vd_reset_en <= wdata_i[BIT_VD_RESET_EN];
        mode <= wdata_i[1:0];
      end
      if (wr_wcount) begin
        wu_count <= wdata_i;
      end
      if (wr_wctrl) begin
        wu_ctrl <= wdata_i;
      end
      if (wr_key) begin
        key_level <= wdata_i[0];
      end
      // blind window after a stop request
      if (stop_req & (state == ST_RUN)) begin
        blind <= BLIND_CNT;
        held_mode <= wr_ctrl ? wdata_i[1:0] : mode;
      end else if (blind_on) begin
        blind <= blind - 4'h1;
      end
      // reset start forces single-clock fast run afterwards
      if (state == ST_RESET) begin
        held_mode <= MODE_SINGLE_FAST;
        mode <= MODE_SINGLE_FAST;
      end
      // irq pin latches across stop; set wins over clear
      if (irq_pin_i) begin
        irq_latch <= 1'b1;
      end else if (rd_i & (addr_i == OFS_STATUS)) begin
        irq_latch <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  // enables follow the held mode while warming or in reset; both are off while stopped
  assign hf_osc_en_o = (state == ST_RUN) ? (mode != MODE_LOW_SLOW)
                     : (state != ST_STOP) & (held_mode != MODE_LOW_SLOW);
  assign lf_osc_en_o = (state == ST_RUN) ? (mode != MODE_SINGLE_FAST)
                     : (state != ST_STOP) & (held_mode != MODE_SINGLE_FAST);
  assign core_halt_o = (state != ST_RUN);
  assign tg_clear_o = (state == ST_WARM) & wu_done;
  assign sys_reset_o = (state == ST_RESET);
  // stop overrides the select field: use the clock that ran before
  assign wu_src_hf_o = (state == ST_WARM) ? (held_mode != MODE_LOW_SLOW)
                     : ~wu_ctrl[BIT_WARMUP_CLOCK_SELECT];
  assign irq_latch_o = irq_latch;
  assign run_mode_o = mode;

  // read mux, registered
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        OFS_SYS_CTRL_ONE: rdata_o <= {1'b0, release_mode_select, vd_reset_en, 3'h0, mode};
        OFS_WARMUP_COUNT: rdata_o <= wu_count;
        OFS_WARMUP_CTRL: rdata_o <= wu_ctrl;
        OFS_KEY_CTRL: rdata_o <= {7'h00, key_level};
        OFS_STATUS: rdata_o <= {3'h0, irq_latch, wu_busy, 1'b0, state};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // smr_stop_ctrl

// ### src/smr_pkg.sv
// package for the stop mode release controller
// assumes a single system clock and a plain register port
package smr_pkg;
  // ***********************************************************
  // register offsets and fields
  // ***********************************************************
  localparam logic [3:0] OFS_SYS_CTRL_ONE = 4'h0;
  localparam logic [3:0] OFS_WARMUP_COUNT = 4'h1;
  localparam logic [3:0] OFS_WARMUP_CTRL = 4'h2;
  localparam logic [3:0] OFS_KEY_CTRL = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam int BIT_STOP = 7;
  localparam int BIT_RELEASE_MODE_SELECT = 6;
  localparam int BIT_VD_RESET_EN = 5;
  localparam int BIT_MODE_LO = 0;
  localparam int BIT_WARMUP_CLOCK_SELECT = 0;
  // ***********************************************************
  // reset values and counts
  // ***********************************************************
  localparam logic [7:0] RST_SYS_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_WARMUP_COUNT = 8'hff;
  localparam logic [7:0] RST_WARMUP_CTRL = 8'h00;
  localparam logic [7:0] RST_KEY_CTRL = 8'h00;
  // one machine cycle, in ns, at 125 MHz ref clock
  localparam int MACHINE_CYCLE_NS = 8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int BLIND_CYCLES = (MACHINE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] BLIND_CNT = 4'(BLIND_CYCLES);
  // warm-up counter unit: ref clock cycles per warm-up tick
  localparam logic [7:0] WU_TICK_DIV = 8'h10;
  // ***********************************************************
  // modes
  // ***********************************************************
  typedef enum logic [1:0] {
    MODE_SINGLE_FAST = 2'h0,
    MODE_DUAL_FAST = 2'h1,
    MODE_LOW_SLOW = 2'h2
  } smr_mode_e;
endpackage

// ### src/smr_edge_det.sv
// rising edge detector for one input level
// assumes the input is already synchronous to ref_clk_i
`timescale 1ns/10ps
module smr_edge_det (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // level in, pulse out
  input wire logic level_i,
  output logic rise_o
);
  logic last;

  // remember last level; reset takes the input's own level so no false edge follows
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      last <= level_i;
    end else begin
      last <= level_i;
    end
  end

  assign rise_o = level_i & ~last;
endmodule // smr_edge_det

// ### src/smr_warmup_cnt.sv
// warm-up counter: prescaled down counter
// assumes start_i is a one cycle pulse
`timescale 1ns/10ps
module smr_warmup_cnt
  import smr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // control
  input wire logic start_i,
  input wire logic [7:0] count_i,
  input wire logic [7:0] div_i,
  // status
  output logic busy_o,
  output logic done_o
);
  logic [7:0] pre;
  logic [7:0] cnt;
  logic [7:0] div_lim;

  // zero divider is treated as one tick per cycle
  assign div_lim = (div_i == 8'h00) ? 8'h00 : div_i - 8'h01;

  // prescaler and tick counter
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pre <= 8'h00;
      cnt <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        pre <= 8'h00;
        cnt <= count_i;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (pre == div_lim) begin
          pre <= 8'h00;
          if (cnt == 8'h00) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end else begin
          pre <= pre + 8'h01;
        end
      end
    end
  end
endmodule // smr_warmup_cnt

// ### tb/smr_far_end.sv
// pin model for the release sources of the stop sequencer
// assumes the bench sets wanted levels on req_i
`timescale 1ns/10ps
module smr_far_end (
  // clock
  input wire logic ref_clk_i,
  // wanted levels: stop pin, key, detector low, reset, irq
  input wire logic [4:0] req_i,
  // pins toward the block, same order
  output logic [4:0] pins_o
);
  // ****
  // pins
  // ****
  // pins move on the first edge after the ask, after the block has sampled that edge
  initial pins_o = 5'h00;
  always @(posedge ref_clk_i) begin
    pins_o <= req_i;
  end
endmodule // smr_far_end

// ### tb/smr_stop_ctrl_asserts.sv
// port assertions for the stop release sequencer
// assumes a bind from the bench top, one clock domain
`timescale 1ns/10ps
module smr_stop_ctrl_chk
  import smr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // inputs watched
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic stop_pin_i,
  // outputs watched
  input wire logic hf_osc_en_o,
  input wire logic lf_osc_en_o,
  input wire logic core_halt_o,
  input wire logic tg_clear_o,
  input wire logic sys_reset_o,
  input wire logic wu_src_hf_o,
  input wire logic [1:0] run_mode_o
);
  // ****
  // state views
  // ****
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  // state read off the enables, since the state itself is hidden
  wire stop_wr = wr_i && addr_i == OFS_SYS_CTRL_ONE && wdata_i[BIT_STOP];
  wire osc_off = !hf_osc_en_o && !lf_osc_en_o;
  wire stopped = osc_off && core_halt_o && !sys_reset_o;
  wire warm = core_halt_o && !sys_reset_o && !osc_off;
  chk_stop_entry: assert property (
    stop_wr && !wdata_i[BIT_RELEASE_MODE_SELECT] && !core_halt_o |=> stopped) else $error("stop not entered");
  chk_level_refuse: assert property (
    stop_wr && wdata_i[BIT_RELEASE_MODE_SELECT] && stop_pin_i && !core_halt_o |=> !core_halt_o) else $error("stop not refused");
  chk_pin_release: assert property (
    stopped [*3] ##1 (stopped && $rose(stop_pin_i)) |-> ##[1:3] !osc_off) else $error("no pin release");
  chk_no_reentry: assert property (
    warm |=> !osc_off || sys_reset_o) else $error("stop re-entered");
  chk_reset_exit: assert property (
    $fell(sys_reset_o) |-> core_halt_o ##[0:1] run_mode_o == MODE_SINGLE_FAST) else $error("bad reset exit");
  chk_tg_pulse: assert property (
    tg_clear_o |=> !tg_clear_o && !core_halt_o) else $error("bad resume pulse");
  chk_single_warm: assert property (
    warm && run_mode_o == MODE_SINGLE_FAST |-> !lf_osc_en_o && wu_src_hf_o) else $error("bad fast warm-up");
  chk_slow_warm: assert property (
    warm && run_mode_o == MODE_LOW_SLOW |-> !hf_osc_en_o && !wu_src_hf_o) else $error("bad slow warm-up");
endmodule // smr_stop_ctrl_chk

// ### tb/smr_stop_ctrl_tb.sv
// bench top for the stop release sequencer
// assumes pin model and checker compile first
`timescale 1ns/10ps
module smr_stop_ctrl_tb
  import smr_pkg::*;
;
  // ****
  // signals and parts
  // ****
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  // asked levels: stop pin, key, detector, reset, irq
  logic [4:0] req = 5'h00;
  wire [4:0] pins;
  wire [7:0] rdata_o;
  wire [1:0] run_mode_o;
  wire hf, lf, wsrc, tgc, rst_o, irq_l, halt;
  int mismatches = 0;
  int tests_run = 0;
  int tg_seen = 0;
  // 125 MHz clock; resume pulses counted as they come
  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (tgc === 1'b1) tg_seen++;
  end
  smr_stop_ctrl i_dut (.ref_clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .stop_pin_i(pins[4]), .key_i(pins[3]), .vd_low_i(pins[2]), .ext_reset_i(pins[1]), .irq_pin_i(pins[0]),
    .hf_osc_en_o(hf), .lf_osc_en_o(lf), .core_halt_o(halt), .tg_clear_o(tgc), .sys_reset_o(rst_o),
    .wu_src_hf_o(wsrc), .irq_latch_o(irq_l), .run_mode_o);
  smr_far_end i_far (.ref_clk_i, .req_i(req), .pins_o(pins));
  // ****
  // bus and check tasks
  // ****
  // looks a little after the edge so launched outputs have settled
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    #1;
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // strobe dropped an edge before the next may rise
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge ref_clk_i);
  endtask
  // poll the state field, bounded by n reads
  task automatic st(input logic [1:0] e, input int n);
    logic [7:0] d;
    rd(OFS_STATUS, d);
    for (int i = 1; i < n && d[1:0] !== e; i++) rd(OFS_STATUS, d);
    chk({6'h00, d[1:0]}, {6'h00, e});
  endtask
  task automatic t_regs();
    logic [7:0] d;
    chk({6'h00, run_mode_o}, 8'h00);
    rd(OFS_WARMUP_COUNT, d);
    chk(d, RST_WARMUP_COUNT);
    rd(4'hf, d);
    chk(d, 8'h00);
    wr(OFS_WARMUP_COUNT, 8'h01);
    wr(OFS_KEY_CTRL, 8'h01);
    $display("register test done");
  endtask
  // pin rises as the stop bit lands, so it must be ignored
  task automatic t_edge();
    req[4] <= 1'b1;
    wr(OFS_SYS_CTRL_ONE, 8'h80);
    repeat (4) @(posedge ref_clk_i);
    st(2'h1, 1);
    chk({6'h00, hf, lf}, 8'h00);
    req[4] <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    req[4] <= 1'b1;
    st(2'h0, 40);
    wr(OFS_SYS_CTRL_ONE, 8'h80);
    st(2'h1, 1);
    req[3] <= 1'b1;
    st(2'h2, 10);
    req[3] <= 1'b0;
    st(2'h0, 40);
    // supply recovers as the stop bit lands: ignored, a later recovery releases
    req[2] <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    req[2] <= 1'b0;
    wr(OFS_SYS_CTRL_ONE, 8'h80);
    repeat (4) @(posedge ref_clk_i);
    st(2'h1, 1);
    req[2] <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    req[2] <= 1'b0;
    st(2'h2, 10);
    st(2'h0, 40);
    $display("edge test done");
  endtask
  task automatic t_level();
    wr(OFS_SYS_CTRL_ONE, 8'h40);
    wr(OFS_SYS_CTRL_ONE, 8'hc0);
    st(2'h0, 1);
    req[4] <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    wr(OFS_SYS_CTRL_ONE, 8'hc0);
    st(2'h1, 1);
    req[0] <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk({7'h00, irq_l}, 8'h01);
    req[0] <= 1'b0;
    req[4] <= 1'b1;
    st(2'h2, 10);
    chk({7'h00, irq_l}, 8'h00);
    req[4] <= 1'b0;
    st(2'h0, 40);
    wr(OFS_SYS_CTRL_ONE, 8'h00);
    $display("level test done");
  endtask
  // low clock picked for warm-up, release must override it
  task automatic t_modes();
    int n;
    logic [1:0] m;
    logic [7:0] e;
    wr(OFS_WARMUP_CTRL, 8'h01);
    for (int i = 0; i < 3; i++) begin
      m = 2'(i);
      n = tg_seen;
      e = {5'h00, m != 2'h2, m != 2'h0, m != 2'h2};
      req[4] <= 1'b0;
      wr(OFS_SYS_CTRL_ONE, {6'h00, m});
      wr(OFS_SYS_CTRL_ONE, {6'h20, m});
      st(2'h1, 1);
      req[4] <= 1'b1;
      st(2'h2, 10);
      chk({5'h00, hf, lf, wsrc}, e);
      st(2'h0, 40);
      chk({6'h00, run_mode_o}, {6'h00, m});
      chk(8'(tg_seen - n), 8'h01);
    end
    $display("mode test done");
  endtask
  // external reset, then detector reset, each from stop in dual mode
  task automatic t_resets();
    for (int s = 1; s < 3; s++) begin
      wr(OFS_SYS_CTRL_ONE, 8'h21);
      wr(OFS_SYS_CTRL_ONE, 8'ha1);
      st(2'h1, 1);
      req[s] <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      chk({7'h00, rst_o}, 8'h01);
      req[s] <= 1'b0;
      st(2'h0, 2500);
      chk({6'h00, run_mode_o}, 8'h00);
    end
    $display("reset test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****
  // run
  // ****
  initial begin
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    st(2'h0, 2500);
    t_regs();
    t_edge();
    t_level();
    t_modes();
    t_resets();
    final_report();
  end
  // cut a hang short, well past the one long warm-up out of reset
  initial begin
    #(CLK_PERIOD_NS * 40000);
    mismatches++;
    final_report();
  end
endmodule // smr_stop_ctrl_tb
bind smr_stop_ctrl smr_stop_ctrl_chk i_chk (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .stop_pin_i(stop_pin_i), .hf_osc_en_o(hf_osc_en_o), .lf_osc_en_o(lf_osc_en_o), .core_halt_o(core_halt_o),
  .tg_clear_o(tg_clear_o), .sys_reset_o(sys_reset_o), .wu_src_hf_o(wu_src_hf_o), .run_mode_o(run_mode_o)
);
